// ---- verilog/tmrc_pkg.sv ----
/*
  Constants shared by the timer control block: special function register
  addresses, bit positions, reset values, interrupt vector addresses and
  the prescaler count.
  Assumes a core that addresses special function registers with 8 bits and
  reports interrupt vectoring with a 16-bit program address.
*/
package tmrc_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8E;
  localparam logic [7:0] TMR_LOW_ADDR [2] = '{8'h8A, 8'h8B};
  localparam logic [7:0] TMR_HIGH_ADDR [2] = '{8'h8C, 8'h8D};

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TIMER_BYTE_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic PIN_IDLE = 1'b1;

  // ----------------------------------------------------------------------
  // Bit positions, index 0 is timer/interrupt A, index 1 is B
  // ----------------------------------------------------------------------
  localparam int TMR_OVF_BIT [2] = '{5, 7};
  localparam int TMR_RUN_BIT [2] = '{4, 6};
  localparam int EXT_FLAG_BIT [2] = '{1, 3};
  localparam int EXT_EDGE_BIT [2] = '{0, 2};
  localparam int TMR_GATE_BIT [2] = '{3, 7};
  localparam int TMR_CT_BIT [2] = '{2, 6};
  localparam int TMR_MODE_LSB [2] = '{0, 4};
  localparam int TMR_CLK_BIT [2] = '{3, 4};

  // ----------------------------------------------------------------------
  // Interrupt vector addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] EXT_VEC [2] = '{16'h0003, 16'h0013};
  localparam logic [15:0] TMR_VEC [2] = '{16'h000B, 16'h001B};

  // ----------------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------------
  localparam logic [3:0] PRESCALE_LAST = 4'hB;
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  localparam logic [4:0] LOW_FIELD_MAX = 5'h1F;
  localparam logic [4:0] LOW_FIELD_ONE = 5'h01;
  localparam logic [4:0] LOW_FIELD_ZERO = 5'h00;
  localparam logic [7:0] HIGH_MAX = 8'hFF;
  localparam logic [7:0] HIGH_ONE = 8'h01;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } tmrc_mode_e;

endpackage

// ---- verilog/tmrc_pin_sync.sv ----
/*
  Two-stage synchroniser for one external pin with falling edge detection.
  Assumes the pin is asynchronous to core_clk_in and idles high.
*/
`timescale 1ns/1ps
module tmrc_pin_sync (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic pin_in,
  output logic level_out,
  output logic fall_out
);

  logic meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;

  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= tmrc_pkg::PIN_IDLE;
      sync_q <= tmrc_pkg::PIN_IDLE;
      prev_q <= tmrc_pkg::PIN_IDLE;
    end else if (ce_in) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // Each high-to-low transition gives one pulse
  assign level_out = sync_q;
  assign fall_out = prev_q & ~sync_q;

endmodule

// ---- verilog/tmrc_counter13.sv ----
/*
  One timer: low and high byte, counting in the 13-bit mode only.
  Assumes the caller supplies a one-cycle increment request and byte writes
  from the special function register bus.
*/
`timescale 1ns/1ps
module tmrc_counter13 (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic inc_in,
  input wire tmrc_pkg::tmrc_mode_e mode_in,
  input wire logic low_wr_in,
  input wire logic high_wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] low_out,
  output logic [7:0] high_out,
  output logic overflow_out
);

  logic [7:0] low_q, low_d, high_q, high_d;
  logic ovf;

  always_comb begin
    low_d = low_q;
    high_d = high_q;
    ovf = 1'b0;
    if (low_wr_in) begin
      low_d = wdata_in;
    end
    if (high_wr_in) begin
      high_d = wdata_in;
    end
    // Software writes win over counting; other modes hold their count
    if (inc_in && mode_in == tmrc_pkg::MODE_13BIT && !low_wr_in && !high_wr_in) begin
      // Upper low-byte bits keep whatever was written
      if (low_q[4:0] == tmrc_pkg::LOW_FIELD_MAX) begin
        low_d = {low_q[7:5], tmrc_pkg::LOW_FIELD_ZERO};
        high_d = high_q + tmrc_pkg::HIGH_ONE;
        ovf = (high_q == tmrc_pkg::HIGH_MAX);
      end else begin
        low_d = {low_q[7:5], low_q[4:0] + tmrc_pkg::LOW_FIELD_ONE};
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_q <= tmrc_pkg::TIMER_BYTE_RESET;
      high_q <= tmrc_pkg::TIMER_BYTE_RESET;
    end else if (ce_in) begin
      low_q <= low_d;
      high_q <= high_d;
    end
  end

  assign low_out = low_q;
  assign high_out = high_q;
  assign overflow_out = ovf;

endmodule

// ---- verilog/tmrc_timer_ctrl.sv ----
/*
  Control and status for two timers and two external interrupt flags:
  control, mode and clock control registers, prescaler, pin synchronisers,
  gating and the two 13-bit counters.
  Assumes the core writes registers with a one-cycle strobe and signals
  interrupt vectoring with a one-cycle pulse and the vector address.
*/
`timescale 1ns/1ps

module tmrc_timer_ctrl (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic vector_ack_in,
  input wire logic [15:0] vector_addr_in,
  input wire logic ext_irq_a_pin_in,
  input wire logic ext_irq_b_pin_in,
  input wire logic count_input_a_in,
  input wire logic count_input_b_in,
  output logic timer_a_irq_out,
  output logic timer_b_irq_out,
  output logic ext_irq_a_irq_out,
  output logic ext_irq_b_irq_out
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0] ctl_q, ctl_d, mode_q, mode_d, clkctl_q, clkctl_d;
  logic [7:0] rdata_q, rdata_d;
  logic [3:0] pre_q, pre_d;
  logic pre_tick, ctl_wr;
  logic [3:0] pins, pin_level, pin_fall;
  logic [1:0] ext_level, ext_fall, cnt_fall;
  logic [1:0] tmr_inc, tmr_ovf, low_wr, high_wr;
  logic [7:0] tmr_low [2];
  logic [7:0] tmr_high [2];
  tmrc_pkg::tmrc_mode_e tmr_mode [2];

  function automatic logic ack_hit(input logic ack, input logic [15:0] addr, input logic [15:0] vec);
    ack_hit = ack && (addr == vec);
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  assign pins = {count_input_b_in, count_input_a_in, ext_irq_b_pin_in, ext_irq_a_pin_in};

  generate
    for (genvar p = 0; p < 4; p++) begin : g_sync
      tmrc_pin_sync u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .pin_in(pins[p]),
        .level_out(pin_level[p]),
        .fall_out(pin_fall[p])
      );
    end
  endgenerate

  assign ext_level = pin_level[1:0];
  assign ext_fall = pin_fall[1:0];
  assign cnt_fall = pin_fall[3:2];

  // ----------------------------------------------------------------------
  // Prescaler, one tick every twelve clocks
  // ----------------------------------------------------------------------
  assign pre_tick = (pre_q == tmrc_pkg::PRESCALE_LAST);

  always_comb begin
    pre_d = pre_tick ? tmrc_pkg::PRESCALE_RESET : pre_q + 4'h1;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_q <= tmrc_pkg::PRESCALE_RESET;
    end else if (ce_in) begin
      pre_q <= pre_d;
    end
  end

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  generate
    for (genvar t = 0; t < 2; t++) begin : g_tmr
      logic run_gate, src_tick;
      assign tmr_mode[t] = tmrc_pkg::tmrc_mode_e'(mode_q[tmrc_pkg::TMR_MODE_LSB[t] +: 2]);
      assign low_wr[t] = sfr_wr_in && (sfr_addr_in == tmrc_pkg::TMR_LOW_ADDR[t]);
      assign high_wr[t] = sfr_wr_in && (sfr_addr_in == tmrc_pkg::TMR_HIGH_ADDR[t]);
      // Run bit, optionally gated by the interrupt pin level
      assign run_gate = ctl_q[tmrc_pkg::TMR_RUN_BIT[t]] &&
                        (!mode_q[tmrc_pkg::TMR_GATE_BIT[t]] || ext_level[t]);
      // Event counting or clock counting at full or twelfth rate
      assign src_tick = mode_q[tmrc_pkg::TMR_CT_BIT[t]] ? cnt_fall[t] :
                        (clkctl_q[tmrc_pkg::TMR_CLK_BIT[t]] ? 1'b1 : pre_tick);
      assign tmr_inc[t] = run_gate && src_tick;

      tmrc_counter13 u_cnt (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .inc_in(tmr_inc[t]),
        .mode_in(tmr_mode[t]),
        .low_wr_in(low_wr[t]),
        .high_wr_in(high_wr[t]),
        .wdata_in(sfr_wdata_in),
        .low_out(tmr_low[t]),
        .high_out(tmr_high[t]),
        .overflow_out(tmr_ovf[t])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Control, mode and clock control registers
  // ----------------------------------------------------------------------
  assign ctl_wr = sfr_wr_in && (sfr_addr_in == tmrc_pkg::ADDR_IRQ_CONTROL);

  always_comb begin
    ctl_d = ctl_q;
    mode_d = mode_q;
    clkctl_d = clkctl_q;
    if (ctl_wr) begin
      ctl_d = sfr_wdata_in;
    end
    if (sfr_wr_in && sfr_addr_in == tmrc_pkg::ADDR_MODE) begin
      mode_d = sfr_wdata_in;
    end
    if (sfr_wr_in && sfr_addr_in == tmrc_pkg::ADDR_CLOCK_CONTROL) begin
      clkctl_d = sfr_wdata_in;
    end
    for (int i = 0; i < 2; i++) begin
      // Vectoring clears, overflow sets, set wins
      if (ack_hit(vector_ack_in, vector_addr_in, tmrc_pkg::TMR_VEC[i])) begin
        ctl_d[tmrc_pkg::TMR_OVF_BIT[i]] = 1'b0;
      end
      if (tmr_ovf[i]) begin
        ctl_d[tmrc_pkg::TMR_OVF_BIT[i]] = 1'b1;
      end
      if (ctl_q[tmrc_pkg::EXT_EDGE_BIT[i]]) begin
        // Edge mode: software or vectoring clears, falling edge sets
        if (ack_hit(vector_ack_in, vector_addr_in, tmrc_pkg::EXT_VEC[i])) begin
          ctl_d[tmrc_pkg::EXT_FLAG_BIT[i]] = 1'b0;
        end
        if (ext_fall[i]) begin
          ctl_d[tmrc_pkg::EXT_FLAG_BIT[i]] = 1'b1;
        end
      end else begin
        // Level mode: flag tracks the low pin, writes have no effect
        ctl_d[tmrc_pkg::EXT_FLAG_BIT[i]] = ~ext_level[i];
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_q <= tmrc_pkg::CONTROL_RESET;
      mode_q <= tmrc_pkg::MODE_RESET;
      clkctl_q <= tmrc_pkg::CLOCK_CONTROL_RESET;
    end else if (ce_in) begin
      ctl_q <= ctl_d;
      mode_q <= mode_d;
      clkctl_q <= clkctl_d;
    end
  end

  // ----------------------------------------------------------------------
  // Read data, registered and held until the next read
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd_in) begin
      rdata_d = tmrc_pkg::READ_IDLE;
      if (sfr_addr_in == tmrc_pkg::ADDR_IRQ_CONTROL) begin
        rdata_d = ctl_q;
      end
      if (sfr_addr_in == tmrc_pkg::ADDR_MODE) begin
        rdata_d = mode_q;
      end
      if (sfr_addr_in == tmrc_pkg::ADDR_CLOCK_CONTROL) begin
        rdata_d = clkctl_q;
      end
      for (int i = 0; i < 2; i++) begin
        if (sfr_addr_in == tmrc_pkg::TMR_LOW_ADDR[i]) begin
          rdata_d = tmr_low[i];
        end
        if (sfr_addr_in == tmrc_pkg::TMR_HIGH_ADDR[i]) begin
          rdata_d = tmr_high[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= tmrc_pkg::READ_IDLE;
    end else if (ce_in) begin
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata_out = rdata_q;
  assign timer_a_irq_out = ctl_q[tmrc_pkg::TMR_OVF_BIT[0]];
  assign timer_b_irq_out = ctl_q[tmrc_pkg::TMR_OVF_BIT[1]];
  assign ext_irq_a_irq_out = ctl_q[tmrc_pkg::EXT_FLAG_BIT[0]];
  assign ext_irq_b_irq_out = ctl_q[tmrc_pkg::EXT_FLAG_BIT[1]];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_tmr_b_flag: assert property (ce_in && tmr_ovf[1] |=> timer_b_irq_out)
    else $error("timer B overflow did not set its flag");
  a_tmr_a_flag: assert property (ce_in && tmr_ovf[0] |=> timer_a_irq_out)
    else $error("timer A overflow did not set its flag");
  a_tmr_a_ack: assert property (ce_in && timer_a_irq_out && ack_hit(vector_ack_in, vector_addr_in,
      tmrc_pkg::TMR_VEC[0]) && !tmr_ovf[0] |=> !timer_a_irq_out)
    else $error("timer A flag not cleared on vectoring");
  a_tmr_b_ack: assert property (ce_in && ack_hit(vector_ack_in, vector_addr_in, tmrc_pkg::TMR_VEC[1])
      && !tmr_ovf[1] |=> !timer_b_irq_out)
    else $error("timer B flag not cleared on vectoring");
  a_run_hold: assert property (ce_in && !ctl_q[tmrc_pkg::TMR_RUN_BIT[0]] && !low_wr[0] && !high_wr[0]
      |=> $stable(tmr_low[0]) && $stable(tmr_high[0]))
    else $error("timer A counted with run bit clear");
  a_edge_b_set: assert property (ce_in && ctl_q[tmrc_pkg::EXT_EDGE_BIT[1]] && ext_fall[1]
      |=> ext_irq_b_irq_out)
    else $error("falling edge on pin B not flagged");
  a_level_b_track: assert property (ce_in && !ctl_q[tmrc_pkg::EXT_EDGE_BIT[1]]
      |=> ext_irq_b_irq_out == !$past(ext_level[1]))
    else $error("level flag B does not follow pin");
  a_edge_a_set: assert property (ce_in && ctl_q[tmrc_pkg::EXT_EDGE_BIT[0]] && ext_fall[0]
      |=> ext_irq_a_irq_out)
    else $error("falling edge on pin A not flagged");
  a_level_a_track: assert property (ce_in && !ctl_q[tmrc_pkg::EXT_EDGE_BIT[0]] && ctl_wr
      |=> ext_irq_a_irq_out == !$past(ext_level[0]))
    else $error("software write changed level flag A");
  a_mode0_carry: assert property (ce_in && tmr_inc[0] && tmr_mode[0] == tmrc_pkg::MODE_13BIT
      && tmr_low[0][4:0] == tmrc_pkg::LOW_FIELD_MAX && !low_wr[0] && !high_wr[0]
      |=> tmr_low[0][4:0] == tmrc_pkg::LOW_FIELD_ZERO
      && tmr_high[0] == $past(tmr_high[0]) + tmrc_pkg::HIGH_ONE)
    else $error("13-bit carry from low field wrong");
  a_wrap_zero: assert property (ce_in && tmr_ovf[1] |=> tmr_high[1] == tmrc_pkg::TIMER_BYTE_RESET
      && tmr_low[1][4:0] == tmrc_pkg::LOW_FIELD_ZERO && timer_b_irq_out)
    else $error("timer B did not wrap to zero");
  a_gate_block: assert property (mode_q[tmrc_pkg::TMR_GATE_BIT[0]] && !ext_level[0] |-> !tmr_inc[0])
    else $error("gated timer A counted with pin low");
  a_counter_src: assert property (mode_q[tmrc_pkg::TMR_CT_BIT[1]] && !cnt_fall[1] |-> !tmr_inc[1])
    else $error("counter B counted without an input edge");
  a_prescale_gap: assert property (ce_in && pre_tick |=> !pre_tick [*8])
    else $error("prescaler ticks too often");
  a_edge_once: assert property (pin_fall[2] |=> !pin_fall[2])
    else $error("count input edge seen twice");
  a_ext_a_ack: assert property (ce_in && ctl_q[tmrc_pkg::EXT_EDGE_BIT[0]] && !ext_fall[0]
      && ack_hit(vector_ack_in, vector_addr_in, tmrc_pkg::EXT_VEC[0]) |=> !ext_irq_a_irq_out)
    else $error("ext flag A not cleared on vectoring");
  a_ext_b_ack: assert property (ce_in && ctl_q[tmrc_pkg::EXT_EDGE_BIT[1]] && !ext_fall[1]
      && ack_hit(vector_ack_in, vector_addr_in, tmrc_pkg::EXT_VEC[1]) |=> !ext_irq_b_irq_out)
    else $error("ext flag B not cleared on vectoring");
  a_run_b_hold: assert property (ce_in && !ctl_q[tmrc_pkg::TMR_RUN_BIT[1]] && !low_wr[1] && !high_wr[1]
      |=> $stable(tmr_low[1]) && $stable(tmr_high[1]))
    else $error("timer B counted with run bit clear");
  a_gate_b_block: assert property (mode_q[tmrc_pkg::TMR_GATE_BIT[1]] && !ext_level[1] |-> !tmr_inc[1])
    else $error("gated timer B counted with pin low");
  a_counter_a_src: assert property (mode_q[tmrc_pkg::TMR_CT_BIT[0]] && !cnt_fall[0] |-> !tmr_inc[0])
    else $error("counter A counted without an input edge");
  a_wrap_a_zero: assert property (ce_in && tmr_ovf[0] |=> tmr_high[0] == tmrc_pkg::TIMER_BYTE_RESET
      && tmr_low[0][4:0] == tmrc_pkg::LOW_FIELD_ZERO && timer_a_irq_out)
    else $error("timer A did not wrap to zero");

  c_tmr_a_ovf: cover property (ce_in && tmr_ovf[0]);
  c_ext_b_edge: cover property (ce_in && ctl_q[tmrc_pkg::EXT_EDGE_BIT[1]] && ext_fall[1]);
  c_tmr_ack: cover property (ce_in && timer_a_irq_out && ack_hit(vector_ack_in, vector_addr_in,
      tmrc_pkg::TMR_VEC[0]));
  c_counter_inc: cover property (ce_in && tmr_inc[1] && mode_q[tmrc_pkg::TMR_CT_BIT[1]]);
  c_gate_b_hold: cover property (mode_q[tmrc_pkg::TMR_GATE_BIT[1]] && !ext_level[1] && cnt_fall[1]);

endmodule

// ---- verification/tmrc_core_model.sv ----
/*
  Behavioural processor core and pin driver for the timer control block.
  Assumes a free-running core clock; every signal changes 2 ns after a rising edge.
*/
`timescale 1ns/1ps
module tmrc_core_model (
  input wire logic core_clk_in,
  output logic [7:0] sfr_addr_out,
  output logic sfr_wr_out,
  output logic sfr_rd_out,
  output logic [7:0] sfr_wdata_out,
  output logic vector_ack_out,
  output logic [15:0] vector_addr_out,
  output logic [3:0] pins_out
);
  // Pin order: ext a, ext b, count a, count b; all idle high
  initial begin
    {sfr_addr_out, sfr_wr_out, sfr_rd_out, sfr_wdata_out} = '0;
    {vector_ack_out, vector_addr_out} = '0;
    pins_out = 4'hF;
  end

  // One-cycle strobe; released lines show the inverse of the last value
  // Run bits only change through software writes here
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    #2;
    sfr_addr_out = a;
    sfr_wdata_out = d;
    sfr_wr_out = wr;
    sfr_rd_out = !wr;
    @(posedge core_clk_in);
    #2;
    sfr_wr_out = 1'b0;
    sfr_rd_out = 1'b0;
    sfr_addr_out = ~a;
    sfr_wdata_out = ~d;
  endtask

  task automatic vec(input logic [15:0] a);
    @(posedge core_clk_in);
    #2;
    vector_addr_out = a;
    vector_ack_out = 1'b1;
    @(posedge core_clk_in);
    #2;
    vector_ack_out = 1'b0;
    vector_addr_out = ~a;
  endtask

  task automatic pin(input int i, input logic v, input int hold);
    @(posedge core_clk_in);
    #2;
    pins_out[i] = v;
    repeat (hold) @(posedge core_clk_in);
  endtask
endmodule

// ---- verification/timer01_control_and_ext_irq_flags_test.sv ----
/*
  Self-checking bench for the timer control block, driven by a core model.
  Assumes the design answers reads one cycle after the strobe edge.
*/
`timescale 1ns/1ps
module timer01_control_and_ext_irq_flags_test;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr, wdata, rdata, h, d;
  logic wr, rd, ack, rd_seen, ok;
  logic [15:0] vaddr;
  logic [15:0] lfsr = 16'h925D;
  logic [3:0] pins;
  logic [1:0] tmr_irq, ext_irq;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  int err_count = 0;
  int samples_checked = 0;
  int n;
  logic [15:0] vecs [2] = '{16'h0003, 16'h0013};

  always #12.5 core_clk_in = ~core_clk_in;

  tmrc_core_model core_u (.core_clk_in(core_clk_in), .sfr_addr_out(addr), .sfr_wr_out(wr),
    .sfr_rd_out(rd), .sfr_wdata_out(wdata), .vector_ack_out(ack), .vector_addr_out(vaddr), .pins_out(pins));

  tmrc_timer_ctrl dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce), .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .vector_ack_in(ack),
    .vector_addr_in(vaddr), .ext_irq_a_pin_in(pins[0]), .ext_irq_b_pin_in(pins[1]),
    .count_input_a_in(pins[2]), .count_input_b_in(pins[3]), .timer_a_irq_out(tmr_irq[0]),
    .timer_b_irq_out(tmr_irq[1]), .ext_irq_a_irq_out(ext_irq[0]), .ext_irq_b_irq_out(ext_irq[1]));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    samples_checked++;
    if ((got & m) !== (exp & m)) begin
      err_count++;
      $display("mismatch %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    core_u.bus(1'b0, a, 8'h00);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    core_u.bus(1'b1, a, v);
  endtask

  task automatic pulse(input int i);
    core_u.pin(i, 1'b0, 5);
    core_u.pin(i, 1'b1, 5);
  endtask

  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Read results are compared against the oldest note
  always @(posedge core_clk_in) begin
    rd_seen <= rd;
  end
  always @(negedge core_clk_in) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("mismatch %0t unexpected read", $time);
      end else begin
        cmp_byte(rdata, exp_q.pop_front(), msk_q.pop_front());
      end
    end
  end

  initial begin
    #(25 * 40000);
    err_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk_in);
    #2;
    rst_in = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd_chk(8'h88 + i[7:0], 8'h00, 8'hFF);
    end
    d = rnd();
    wr_reg(8'h89, d);
    rd_chk(8'h89, d, 8'hFF);
    wr_reg(8'h90, rnd());
    rd_chk(8'h90, 8'h00, 8'hFF);
    // Counter mode carry from 31 into the high byte
    h = rnd() >> 1;
    wr_reg(8'h89, 8'h04);
    wr_reg(8'h8A, 8'h1F);
    wr_reg(8'h8C, h);
    wr_reg(8'h88, 8'h10);
    pulse(2);
    repeat (20) @(posedge core_clk_in);
    rd_chk(8'h8A, 8'h00, 8'h1F);
    rd_chk(8'h8C, h + 8'h01, 8'hFF);
    // Gate holds the count while ext pin a is low
    wr_reg(8'h89, 8'h0C);
    core_u.pin(0, 1'b0, 2);
    pulse(2);
    rd_chk(8'h8A, 8'h00, 8'h1F);
    core_u.pin(0, 1'b1, 2);
    pulse(2);
    rd_chk(8'h8A, 8'h01, 8'h1F);
    wr_reg(8'h88, 8'h00);
    pulse(2);
    rd_chk(8'h8A, 8'h01, 8'h1F);
    wr_reg(8'h89, 8'h05);
    wr_reg(8'h88, 8'h10);
    pulse(2);
    rd_chk(8'h8A, 8'h01, 8'h1F);
    // Rollover from the top value
    wr_reg(8'h89, 8'h04);
    wr_reg(8'h8A, 8'h1F);
    wr_reg(8'h8C, 8'hFF);
    pulse(2);
    cmp_bit(tmr_irq[0], 1'b1);
    rd_chk(8'h8A, 8'h00, 8'h1F);
    rd_chk(8'h8C, 8'h00, 8'hFF);
    rd_chk(8'h88, 8'h30, 8'hFF);
    core_u.vec(16'h0013);
    cmp_bit(tmr_irq[0], 1'b1);
    core_u.vec(16'h000B);
    cmp_bit(tmr_irq[0], 1'b0);
    wr_reg(8'h88, 8'h00);
    // Timer b rate: every clock, then every twelfth clock
    wr_reg(8'h89, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr_reg(8'h8E, (s == 0) ? 8'h10 : 8'h00);
      wr_reg(8'h8B, 8'h1E);
      wr_reg(8'h8D, 8'hFF);
      wr_reg(8'h88, 8'h40);
      n = 0;
      while (tmr_irq[1] !== 1'b1 && n < 40) begin
        @(posedge core_clk_in);
        #1;
        n++;
      end
      ok = (s == 0) ? (n <= 4) : (n >= 12 && n <= 27);
      cmp_bit(ok, 1'b1);
      core_u.vec(16'h001B);
      cmp_bit(tmr_irq[1], 1'b0);
      wr_reg(8'h88, 8'h00);
    end
    // Clock enable low freezes a timer counting every clock
    wr_reg(8'h8E, 8'h08);
    wr_reg(8'h8A, 8'h00);
    wr_reg(8'h88, 8'h10);
    ce = 1'b0;
    repeat (20) @(posedge core_clk_in);
    #2;
    ce = 1'b1;
    rd_chk(8'h8A, 8'h01, 8'h1F);
    wr_reg(8'h88, 8'h00);
    // Timer b counts input edges, holds in the reload and split modes and while gated
    wr_reg(8'h89, 8'h40);
    wr_reg(8'h8B, 8'h00);
    wr_reg(8'h88, 8'h40);
    pulse(3);
    rd_chk(8'h8B, 8'h01, 8'h1F);
    for (int m = 2; m < 4; m++) begin
      wr_reg(8'h89, 8'h40 | (m[7:0] << 4));
      pulse(3);
      rd_chk(8'h8B, 8'h01, 8'h1F);
    end
    wr_reg(8'h89, 8'hC0);
    core_u.pin(1, 1'b0, 2);
    pulse(3);
    rd_chk(8'h8B, 8'h01, 8'h1F);
    core_u.pin(1, 1'b1, 2);
    pulse(3);
    rd_chk(8'h8B, 8'h02, 8'h1F);
    wr_reg(8'h88, 8'h00);
    // Edge mode: vector clears, then software clears
    wr_reg(8'h88, 8'h05);
    for (int i = 0; i < 2; i++) begin
      pulse(i);
      cmp_bit(ext_irq[i], 1'b1);
      core_u.vec(vecs[i]);
      cmp_bit(ext_irq[i], 1'b0);
      pulse(i);
      cmp_bit(ext_irq[i], 1'b1);
      wr_reg(8'h88, 8'h05);
      cmp_bit(ext_irq[i], 1'b0);
    end
    // Level mode: flag follows the pin, writes ignored
    wr_reg(8'h88, 8'h00);
    for (int i = 0; i < 2; i++) begin
      core_u.pin(i, 1'b0, 5);
      cmp_bit(ext_irq[i], 1'b1);
      wr_reg(8'h88, 8'h00);
      cmp_bit(ext_irq[i], 1'b1);
      core_u.pin(i, 1'b1, 5);
      cmp_bit(ext_irq[i], 1'b0);
      wr_reg(8'h88, 8'h0A);
      cmp_bit(ext_irq[i], 1'b0);
    end
    repeat (2) @(posedge core_clk_in);
    if (exp_q.size() != 0) begin
      err_count++;
      $display("mismatch %0t reads left unanswered", $time);
    end
    wrap_up();
  end
endmodule
